// File: tc_status_pkg.sv
package tc_status_pkg;

  // Register word width and channel value width
  localparam int unsigned DATA_W = 32;
  localparam int unsigned VAL_W  = 16;
  localparam int unsigned FLAG_N = 8;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IEN_SET = 8'h04;
  localparam logic [7:0] OFS_IEN_CLR = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0C;
  localparam logic [7:0] OFS_LIMIT_C = 8'h10;
  localparam logic [7:0] OFS_CC_A   = 8'h14;
  localparam logic [7:0] OFS_CC_B   = 8'h18;
  localparam logic [7:0] OFS_MODE   = 8'h1C;

  // Status bit positions, and BIT_WAVE in the mode word
  localparam int unsigned BIT_OVF  = 0;
  localparam int unsigned BIT_OVR  = 1;
  localparam int unsigned BIT_CMPA = 2;
  localparam int unsigned BIT_CMPB = 3;
  localparam int unsigned BIT_CMPC = 4;
  localparam int unsigned BIT_LDA  = 5;
  localparam int unsigned BIT_LDB  = 6;
  localparam int unsigned BIT_ETRG = 7;
  localparam int unsigned BIT_CLKEN = 16;
  localparam int unsigned BIT_MIRA = 17;
  localparam int unsigned BIT_MIRB = 18;
  localparam int unsigned BIT_WAVE = 0;

  // Flags allowed per mode: capture keeps overrun and loads, waveform the A/B compares
  localparam logic [7:0] CAPTURE_ONLY  = 8'h62;
  localparam logic [7:0] WAVEFORM_ONLY = 8'h0C;

  // Reset values
  localparam logic [7:0]       FLAGS_RST = 8'h00;
  localparam logic [7:0]       MASK_RST  = 8'h00;
  localparam logic [VAL_W-1:0] VAL_RST   = 16'h0000;
  localparam logic             MODE_RST  = 1'b0;
  localparam logic [1:0]       LINE_RST  = 2'h0;

  // Event strobes from the counter datapath, one cycle each
  typedef struct packed {
    logic ext_trigger;
    logic load_b;
    logic load_a;
    logic compare_c;
    logic compare_b;
    logic compare_a;
    logic overflow;
  } timer_events_t;

  // Values captured by the capture engine
  typedef struct packed {
    logic [VAL_W-1:0] b;
    logic [VAL_W-1:0] a;
  } capture_values_t;

  // Levels of the two I/O lines
  typedef struct packed {
    logic line_b;
    logic line_a;
  } line_levels_t;

endpackage

// File: timer_channel_status_irq.sv
// Added by the designer: the Wishbone slave port and the address map.
module timer_channel_status_irq
(
  input  wire logic                            clk,                   // 200 MHz clock
  input  wire logic                            rst_n,                 // Async reset, low
  input  wire logic                            ce,                    // Clock enable
  input  wire logic                            cyc_i,                 // Wishbone cycle
  input  wire logic                            stb_i,                 // Wishbone strobe
  input  wire logic                            we_i,                  // Wishbone write
  input  wire logic [7:0]                      adr_i,                 // Byte address
  input  wire logic [3:0]                      sel_i,                 // Byte lanes
  input  wire logic [tc_status_pkg::DATA_W-1:0] dat_i,                // Write data
  output logic      [tc_status_pkg::DATA_W-1:0] dat_o,                // Read data
  output logic                                 ack_o,                 // Wishbone ack
  input  wire tc_status_pkg::timer_events_t    events,                // Event strobes
  input  wire tc_status_pkg::capture_values_t  capture,               // Captured values
  input  wire logic                            clock_enabled,         // Counter clock on
  input  wire tc_status_pkg::line_levels_t     line_pin,              // Pin levels, async
  input  wire tc_status_pkg::line_levels_t     line_drive,            // Driven levels
  output logic                                 waveform_mode,         // Mode bit
  output logic      [tc_status_pkg::VAL_W-1:0] capture_compare_a,     // Register A
  output logic      [tc_status_pkg::VAL_W-1:0] capture_compare_b,     // Register B
  output logic      [tc_status_pkg::VAL_W-1:0] compare_limit_c,       // Register C
  output logic                                 irq                    // Level interrupt
);
  import tc_status_pkg::*;

  logic                 ack_ff;
  logic [DATA_W-1:0]    rdata_ff;
  logic                 mode_ff;
  logic [VAL_W-1:0]     cc_a_ff;
  logic [VAL_W-1:0]     cc_b_ff;
  logic [VAL_W-1:0]     limit_c_ff;
  logic                 pend_a_ff;
  logic                 pend_b_ff;
  logic [FLAG_N-1:0]    flags_ff;
  logic [FLAG_N-1:0]    nxt_flags;
  logic [FLAG_N-1:0]    mask_ff;
  logic [FLAG_N-1:0]    nxt_mask;
  logic [FLAG_N-1:0]    flag_set;
  logic [FLAG_N-1:0]    flag_clr;
  logic [FLAG_N-1:0]    flags_view;
  logic [1:0]           line_filt_ff;
  logic [1:0]           line_mirror;
  logic [2:0]           sync_ff [2];
  logic [DATA_W-1:0]    nxt_rdata;
  logic                 access;
  logic                 rd;
  logic                 wr;
  logic                 hit_status;
  logic                 hit_ien_set;
  logic                 hit_ien_clr;
  logic                 hit_mask;
  logic                 hit_limit_c;
  logic                 hit_cc_a;
  logic                 hit_cc_b;
  logic                 hit_mode;
  logic                 load_a;
  logic                 load_b;
  logic                 overrun;

  // Bus request taken once; ack then blocks a second take of the same request
  assign access = cyc_i & stb_i & ~ack_ff;
  assign rd     = access & ~we_i;
  assign wr     = access & we_i;

  // Word decode on address bits 7:2
  assign hit_status  = (adr_i[7:2] == OFS_STATUS[7:2]);
  assign hit_ien_set = (adr_i[7:2] == OFS_IEN_SET[7:2]);
  assign hit_ien_clr = (adr_i[7:2] == OFS_IEN_CLR[7:2]);
  assign hit_mask    = (adr_i[7:2] == OFS_MASK[7:2]);
  assign hit_limit_c = (adr_i[7:2] == OFS_LIMIT_C[7:2]);
  assign hit_cc_a    = (adr_i[7:2] == OFS_CC_A[7:2]);
  assign hit_cc_b    = (adr_i[7:2] == OFS_CC_B[7:2]);
  assign hit_mode    = (adr_i[7:2] == OFS_MODE[7:2]);

  // One-cycle ack for every address, mapped or not
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_ff <= 1'b0;
    else if (ce)
      ack_ff <= access;
  end

  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;

  // Operating mode bit, low byte lane
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_ff <= MODE_RST;
    else if (ce && wr && hit_mode && sel_i[0])
      mode_ff <= dat_i[BIT_WAVE];
  end

  assign waveform_mode = mode_ff;

  // Limit C is writable in both modes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      limit_c_ff <= VAL_RST;
    else if (ce && wr && hit_limit_c)
    begin
      if (sel_i[0])
        limit_c_ff[7:0] <= dat_i[7:0];
      if (sel_i[1])
        limit_c_ff[15:8] <= dat_i[15:8];
    end
  end

  assign compare_limit_c = limit_c_ff;

  // Loads only count in capture mode; software writes A and B only in waveform mode
  assign load_a = events.load_a & ~mode_ff;
  assign load_b = events.load_b & ~mode_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cc_a_ff <= VAL_RST;
      cc_b_ff <= VAL_RST;
    end
    else if (ce)
    begin
      if (load_a)
        cc_a_ff <= capture.a;
      else if (wr && hit_cc_a && mode_ff)
      begin
        if (sel_i[0])
          cc_a_ff[7:0] <= dat_i[7:0];
        if (sel_i[1])
          cc_a_ff[15:8] <= dat_i[15:8];
      end
      if (load_b)
        cc_b_ff <= capture.b;
      else if (wr && hit_cc_b && mode_ff)
      begin
        if (sel_i[0])
          cc_b_ff[7:0] <= dat_i[7:0];
        if (sel_i[1])
          cc_b_ff[15:8] <= dat_i[15:8];
      end
    end
  end

  assign capture_compare_a = cc_a_ff;
  assign capture_compare_b = cc_b_ff;

  // Unread-load markers; a load in the same cycle as the read keeps the marker
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_a_ff <= 1'b0;
      pend_b_ff <= 1'b0;
    end
    else if (ce)
    begin
      pend_a_ff <= load_a | (pend_a_ff & ~(rd & hit_cc_a));
      pend_b_ff <= load_b | (pend_b_ff & ~(rd & hit_cc_b));
    end
  end

  assign overrun = (load_a & pend_a_ff) | (load_b & pend_b_ff);

  // Set vector, gated by the mode where the flag belongs to one mode only
  always_comb
  begin
    flag_set           = '0;
    flag_set[BIT_OVF]  = events.overflow;
    flag_set[BIT_OVR]  = overrun;
    flag_set[BIT_CMPA] = events.compare_a & mode_ff;
    flag_set[BIT_CMPB] = events.compare_b & mode_ff;
    flag_set[BIT_CMPC] = events.compare_c;
    flag_set[BIT_LDA]  = load_a;
    flag_set[BIT_LDB]  = load_b;
    flag_set[BIT_ETRG] = events.ext_trigger;
  end

  // Clear on status read, or write-one-to-clear from the low lane
  always_comb
  begin
    flag_clr = '0;
    if (rd && hit_status)
      flag_clr = '1;
    else if (wr && hit_status && sel_i[0])
      flag_clr = dat_i[FLAG_N-1:0];
    nxt_flags = (flags_ff & ~flag_clr) | flag_set; // Set beats clear
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_ff <= FLAGS_RST;
    else if (ce)
      flags_ff <= nxt_flags;
  end

  // Flags of the other mode read as zero, even if left over from a mode change
  assign flags_view = flags_ff & (mode_ff ? ~CAPTURE_ONLY : ~WAVEFORM_ONLY);

  // Mask: enable-set ones set, enable-clear ones clear, zeros ignored
  always_comb
  begin
    nxt_mask = mask_ff;
    if (wr && hit_ien_set && sel_i[0])
      nxt_mask = mask_ff | dat_i[FLAG_N-1:0];
    if (wr && hit_ien_clr && sel_i[0])
      nxt_mask = mask_ff & ~dat_i[FLAG_N-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_ff <= MASK_RST;
    else if (ce)
      mask_ff <= nxt_mask;
  end

  // Interrupt follows the registered flags, mask and mode only
  assign irq = |(flags_view & mask_ff);

  // Pin synchronisers; the filtered level moves only when stages 2 and 3 agree
  for (genvar i = 0; i < 2; i++)
  begin : g_line_sync
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        sync_ff[i]      <= 3'h0;
        line_filt_ff[i] <= LINE_RST[i];
      end
      else if (ce)
      begin
        sync_ff[i] <= {sync_ff[i][1:0], line_pin[i]};
        if (sync_ff[i][1] == sync_ff[i][2])
          line_filt_ff[i] <= sync_ff[i][2];
      end
    end
  end

  // Mirror: driven level in waveform mode, sampled pin in capture mode
  assign line_mirror = mode_ff ? line_drive : line_filt_ff;

  // Read mux; unmapped and write-only words read zero
  always_comb
  begin
    nxt_rdata = '0;
    if (hit_status)
    begin
      nxt_rdata[FLAG_N-1:0] = flags_view;
      nxt_rdata[BIT_CLKEN]  = clock_enabled;
      nxt_rdata[BIT_MIRA]   = line_mirror[0];
      nxt_rdata[BIT_MIRB]   = line_mirror[1];
    end
    else if (hit_mask)
      nxt_rdata[FLAG_N-1:0] = mask_ff;
    else if (hit_limit_c)
      nxt_rdata[VAL_W-1:0] = limit_c_ff;
    else if (hit_cc_a)
      nxt_rdata[VAL_W-1:0] = cc_a_ff;
    else if (hit_cc_b)
      nxt_rdata[VAL_W-1:0] = cc_b_ff;
    else if (hit_mode)
      nxt_rdata[BIT_WAVE] = mode_ff;
  end

  // Read data held from the take until the next read take
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= '0;
    else if (ce && rd)
      rdata_ff <= nxt_rdata;
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ovf_flag_set: assert property (ce && events.overflow |=> flags_ff[BIT_OVF])
    else $error("overflow flag not set");
  a_ovf_read_clear: assert property (
    ce && rd && hit_status && !events.overflow |=> !flags_ff[BIT_OVF])
    else $error("overflow flag not cleared by status read");
  a_overrun_set: assert property (
    ce && !mode_ff && events.load_a && pend_a_ff |=> flags_ff[BIT_OVR])
    else $error("load overrun not flagged");
  a_overrun_single: assert property (
    ce && !mode_ff && !pend_a_ff && !pend_b_ff && rd && hit_status
    ##1 !ce || !(events.load_a || events.load_b) |=> !flags_ff[BIT_OVR])
    else $error("overrun without second load");
  a_cmpa_waveform: assert property (
    ce && mode_ff && events.compare_a && !$changed(mode_ff) |=> flags_view[BIT_CMPA])
    else $error("compare A not flagged in waveform mode");
  a_cmp_capture_zero: assert property (
    !mode_ff |-> !flags_view[BIT_CMPA] && !flags_view[BIT_CMPB])
    else $error("compare A or B visible in capture mode");
  a_cmpc_any_mode: assert property (ce && events.compare_c |=> flags_ff[BIT_CMPC])
    else $error("compare C not flagged");
  a_loads_waveform: assert property (
    mode_ff |-> !flags_view[BIT_LDA] && !flags_view[BIT_LDB] && !flags_view[BIT_OVR])
    else $error("capture flags visible in waveform mode");
  a_trigger_flag: assert property (ce && events.ext_trigger |=> flags_ff[BIT_ETRG])
    else $error("external trigger not flagged");
  a_clken_live: assert property (
    ce && rd && hit_status |=> ack_o && dat_o[BIT_CLKEN] == $past(clock_enabled))
    else $error("clock enable view stale");
  a_mirror_drive: assert property (
    ce && rd && hit_status && mode_ff |=> dat_o[BIT_MIRB:BIT_MIRA] == $past(line_drive))
    else $error("mirror differs from driven level");
  a_mask_enable: assert property (
    ce && wr && hit_ien_set && sel_i[0]
    |=> (mask_ff & $past(dat_i[FLAG_N-1:0])) == $past(dat_i[FLAG_N-1:0]))
    else $error("enable-set did not set mask");
  a_mask_disable: assert property (
    ce && wr && hit_ien_clr && sel_i[0]
    |=> (mask_ff & $past(dat_i[FLAG_N-1:0])) == 8'h00)
    else $error("enable-clear did not clear mask");
  a_mask_readback: assert property (
    ce && rd && hit_mask |=> dat_o[FLAG_N-1:0] == $past(mask_ff))
    else $error("mask readback wrong");
  a_limit_read: assert property (
    ce && rd && hit_limit_c |=> dat_o[VAL_W-1:0] == $past(limit_c_ff))
    else $error("limit C readback wrong");
  a_irq_release: assert property (
    ce && rd && hit_status && events == '0 |=> !irq)
    else $error("interrupt held after status read");
  a_ack_single: assert property (ce && ack_o |=> !ack_o)
    else $error("ack longer than one cycle");

  // Gating and value checks that the read-side views cannot hide
  a_cmpb_waveform: assert property (
    ce && mode_ff && events.compare_b |=> flags_ff[BIT_CMPB])
    else $error("compare B not flagged in waveform mode");
  a_cmp_gated: assert property (
    ce && !mode_ff && !flags_ff[BIT_CMPB] |=> !flags_ff[BIT_CMPB])
    else $error("compare B set in capture mode");
  a_load_value: assert property (
    ce && load_a |=> capture_compare_a == $past(capture.a))
    else $error("capture value not stored in register A");
  a_irq_raise: assert property (
    ce && events.overflow && mask_ff[BIT_OVF] && !(wr && hit_ien_clr) |=> irq)
    else $error("interrupt not raised for enabled flag");
  a_status_w1c: assert property (
    ce && wr && hit_status && sel_i[0] && dat_i[BIT_OVF] && !events.overflow
    |=> !flags_ff[BIT_OVF])
    else $error("write-one did not clear overflow flag");
  a_ce_freeze: assert property (
    !ce |=> $stable(flags_ff) && $stable(mask_ff) && $stable(ack_o) && $stable(rdata_ff))
    else $error("state moved while clock enable low");

  c_irq_rise: cover property ($rose(irq));
  c_overrun: cover property (flags_ff[BIT_OVR]);
  c_read_with_event: cover property (ce && rd && hit_status && events.overflow);
  c_mode_switch: cover property ($rose(mode_ff) ##[1:20] $rose(flags_view[BIT_CMPA]));

endmodule

// File: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tc_status_pkg::*;

  logic                  clk;
  logic                  rst_n;
  logic                  ce;
  logic                  cyc_i;
  logic                  stb_i;
  logic                  we_i;
  logic [7:0]            adr_i;
  logic [3:0]            sel_i;
  logic [DATA_W-1:0]     dat_i;
  logic [DATA_W-1:0]     dat_o;
  logic                  ack_o;
  timer_events_t         events;
  capture_values_t       capture;
  logic                  clock_enabled;
  line_levels_t          line_pin;
  line_levels_t          line_drive;
  logic                  waveform_mode;
  logic [VAL_W-1:0]      capture_compare_a;
  logic [VAL_W-1:0]      capture_compare_b;
  logic [VAL_W-1:0]      compare_limit_c;
  logic                  irq;
  int                    fail_count;
  int                    n_compared;
  // Bench copy of the channel state
  logic [7:0]            flg;
  logic [7:0]            msk;
  logic                  wave;
  logic                  una;
  logic                  unb;
  logic [VAL_W-1:0]      ra;
  logic [VAL_W-1:0]      rb;
  logic [31:0]           q;
  logic [31:0]           v;

  timer_channel_status_irq dut_u (
    .clk               (clk),
    .rst_n             (rst_n),
    .ce                (ce),
    .cyc_i             (cyc_i),
    .stb_i             (stb_i),
    .we_i              (we_i),
    .adr_i             (adr_i),
    .sel_i             (sel_i),
    .dat_i             (dat_i),
    .dat_o             (dat_o),
    .ack_o             (ack_o),
    .events            (events),
    .capture           (capture),
    .clock_enabled     (clock_enabled),
    .line_pin          (line_pin),
    .line_drive        (line_drive),
    .waveform_mode     (waveform_mode),
    .capture_compare_a (capture_compare_a),
    .capture_compare_b (capture_compare_b),
    .compare_limit_c   (compare_limit_c),
    .irq               (irq)
  );

  // Free-running 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Only the flags legal in the present mode are visible
  function automatic logic [7:0] vis();
    return flg & (wave ? ~CAPTURE_ONLY : ~WAVEFORM_ONLY);
  endfunction

  // Expected status word: live bits from what the bench drives
  function automatic logic [31:0] st_exp();
    line_levels_t l;
    l = wave ? line_drive : line_pin;
    return {13'h0, l.line_b, l.line_a, clock_enabled, 8'h00, vis()};
  endfunction

  // Classic single cycle; hold until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      end_of_test();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk32(q, exp);
  endtask

  // Status read clears every flag; irq must drop with them
  task automatic rd_status();
    rd(OFS_STATUS, st_exp());
    flg = 8'h00;
    chk1(irq, 1'b0);
  endtask

  // One-cycle event strobe, then model update and live output checks
  task automatic pulse(input logic [6:0] e);
    logic [31:0] cv;
    cv = $urandom;
    capture <= cv;
    events <= timer_events_t'(e);
    @(posedge clk);
    events <= timer_events_t'(7'h00);
    flg[0] |= e[0];
    flg[2] |= e[1] & wave;
    flg[3] |= e[2] & wave;
    flg[4] |= e[3];
    flg[7] |= e[6];
    if (!wave && e[4])
    begin
      flg[1] |= una;
      flg[5] = 1'b1;
      una = 1'b1;
      ra = cv[15:0];
    end
    if (!wave && e[5])
    begin
      flg[1] |= unb;
      flg[6] = 1'b1;
      unb = 1'b1;
      rb = cv[31:16];
    end
    @(posedge clk);
    chk1(irq, |(vis() & msk));
    chk32({16'h0, capture_compare_a}, {16'h0, ra});
    chk32({16'h0, capture_compare_b}, {16'h0, rb});
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    events = timer_events_t'(7'h00);
    capture = capture_values_t'(32'h0000_0000);
    clock_enabled = 1'b0;
    line_pin = line_levels_t'(2'h0);
    line_drive = line_levels_t'(2'h0);
    fail_count = 0;
    n_compared = 0;
    {flg, msk, wave, una, unb, ra, rb} = '0;
    void'($urandom(48));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped word reads zero
    rd(OFS_STATUS, 32'h0000_0000);
    rd(OFS_MASK, 32'h0000_0000);
    rd(OFS_LIMIT_C, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    chk1(irq, 1'b0);
    $display("test reset done");
    // Mask set and clear with random patterns, all-ones corner first
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      wb(1'b1, OFS_IEN_SET, v);
      msk |= v[7:0];
      rd(OFS_MASK, {24'h0, msk});
      v = (i == 0) ? 32'h0000_005A : $urandom;
      wb(1'b1, OFS_IEN_CLR, v);
      msk &= ~v[7:0];
      rd(OFS_MASK, {24'h0, msk});
    end
    $display("test mask done");
    // Limit C write and immediate read-back
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom;
      wb(1'b1, OFS_LIMIT_C, v);
      rd(OFS_LIMIT_C, {16'h0, v[15:0]});
      chk32({16'h0, compare_limit_c}, {16'h0, v[15:0]});
    end
    $display("test limit done");
    // Overrun corner: two loads of A unread, then loads after a read of A
    pulse(7'h10);
    pulse(7'h10);
    rd_status();
    rd(OFS_CC_A, {16'h0, ra});
    una = 1'b0;
    pulse(7'h30);
    rd_status();
    $display("test overrun done");
    // Random events, pins and accesses in capture then waveform mode
    for (int m = 0; m < 2; m++)
    begin
      wb(1'b1, OFS_MODE, {31'h0, m[0]});
      wave = m[0];
      chk1(waveform_mode, wave);
      rd_status();
      for (int i = 0; i < 40; i++)
      begin
        clock_enabled <= 1'($urandom);
        line_pin <= line_levels_t'(2'($urandom));
        line_drive <= line_levels_t'(2'($urandom));
        // Pins cross a synchroniser and filter, so let them settle
        repeat (6) @(posedge clk);
        pulse(7'($urandom));
        case ($urandom % 4)
          0: rd_status();
          1:
          begin
            rd(OFS_CC_A, {16'h0, ra});
            una = 1'b0;
          end
          2:
          begin
            rd(OFS_CC_B, {16'h0, rb});
            unb = 1'b0;
          end
          default:
          begin
            v = $urandom;
            wb(1'b1, OFS_CC_A, v);
            if (wave)
              ra = v[15:0];
            rd(OFS_CC_A, {16'h0, ra});
            una = 1'b0;
          end
        endcase
      end
      rd_status();
      $display("test events mode %0d done", m);
    end
    // Clock enable low: strobes seen while frozen leave no trace
    ce <= 1'b0;
    events <= timer_events_t'(7'h49);
    @(posedge clk);
    events <= timer_events_t'(7'h00);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    rd_status();
    $display("test freeze done");
    // Write-one clear of status: only the written flags drop
    pulse(7'h49);
    wb(1'b1, OFS_STATUS, 32'h0000_0011);
    flg &= ~8'h11;
    chk1(irq, |(vis() & msk));
    rd_status();
    $display("test write clear done");
    // Mid-run reset: flags, mask and mode return to reset values
    pulse(7'h01);
    rst_n <= 1'b0;
    line_pin <= line_levels_t'(2'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    {flg, msk, wave, una, unb, ra, rb} = '0;
    @(posedge clk);
    chk1(waveform_mode, 1'b0);
    rd(OFS_MASK, 32'h0000_0000);
    rd_status();
    $display("test reset again done");
    end_of_test();
  end

  // Whole run needs well under 20000 cycles
  initial
  begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule
